// ---- common/frec_pkg.sv ----
package frec_pkg;
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int SLOTS = 48;
   localparam int SECT_SLOTS = 24;
   localparam int ERASE_BATCH = 4;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
   localparam int WIPE_MS = 121;
   localparam int WIPE_CYCLES = SYS_CLK_HZ / 1000 * WIPE_MS;
   localparam real CANCEL_YEARS = 2.1;
   localparam int CANCEL_TICKS = $rtoi(CANCEL_YEARS * 365.25 * 86400.0 * 1000.0 / TICK_MS);
   // entry layout, block byte 0 at the top
   localparam int ENTRY_W = 184;
   localparam int ID_LSB = 168;
   localparam int TS_LSB = 136;
   localparam int SW_LSB = 120;
   localparam int STAT_LSB = 64;
   localparam int TELE_LSB = 0;
   localparam logic [7:0] BLOCK_COUNT = 8'h17;
   localparam logic [7:0] EMPTY_BYTE = 8'hFF;
   // commands and index codes
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_READ_EVENT = 8'hD7;
   localparam logic [7:0] CMD_EVENT_INDEX = 8'hDB;
   localparam logic [7:0] IDX_WIPE = 8'hAA;
   localparam logic [7:0] IDX_NEWEST_LIFE = 8'hFE;
   localparam logic [7:0] IDX_NEWEST_FAULT = 8'hFF;
   // status words and vendor byte codes
   localparam logic [15:0] SW_SYSTEM = 16'h0001;
   localparam logic [15:0] SW_UNIT = 16'h0040;
   localparam logic [15:0] SW_POWER_GOOD = 16'h0800;
   localparam logic [7:0] SYS_BOOT = 8'h01;
   localparam logic [7:0] SYS_INPUT_LOW = 8'h02;
   localparam logic [7:0] SYS_CANCEL = 8'h04;
   localparam logic [7:0] SYS_ERASE = 8'h08;
   localparam logic [7:0] SYS_FAULT_CLEAR = 8'h10;
   localparam logic [7:0] SYS_WIPE_OVERLOAD = 8'h20;
   localparam logic [7:0] UNIT_DISABLED_CODE = 8'h00;
   localparam logic [7:0] UNIT_ENABLED_CODE = 8'h04;
   typedef enum logic [1:0] {SRC_CFG = 2'b00, SRC_PRIMARY = 2'b01, SRC_SECONDARY = 2'b10, SRC_BUS = 2'b11} frec_src_e;
   typedef enum logic [0:0] {ST_RUN = 1'b0, ST_WIPE = 1'b1} frec_state_e;
endpackage

// ---- common/frec_link_if.sv ----
`timescale 1ns/1ps
interface frec_link_if;
   logic wr_tgl;
   logic clr_tgl;
   logic [7:0] index_byte;
   logic prep_tgl;
   logic [7:0] readback;
   logic [frec_pkg::ENTRY_W-1:0] block;
   modport link (output wr_tgl, output clr_tgl, output index_byte, input prep_tgl, input readback, input block);
   modport core (input wr_tgl, input clr_tgl, input index_byte, output prep_tgl, output readback, output block);
endinterface

// ---- hdl/frec_sync.sv ----
`timescale 1ns/1ps
module frec_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ---- hdl/frec_link.sv ----
`timescale 1ns/1ps
module frec_link (
   // link clock and reset
   input wire logic link_clk,
   input wire logic link_rst_n,
   // framed byte stream
   input wire logic link_frame,
   input wire logic link_rx_valid,
   input wire logic [7:0] link_rx_byte,
   input wire logic link_tx_req,
   output logic [7:0] link_tx_byte,
   // crossing to the core
   frec_link_if.link lk
);
   logic in_frame;
   logic got_data;
   logic [7:0] cmd;
   logic [4:0] tx_cnt;
   logic prep_s;
   logic [7:0] blk_byte;
   logic [7:0] next_tx;
   wire ready = (prep_s == lk.wr_tgl);
   wire first = link_rx_valid && !in_frame;
   frec_sync #(.W(1)) u_prep (.clk(link_clk), .rst_n(link_rst_n), .d(lk.prep_tgl), .q(prep_s));
   // request 1 carries the block count, request k (k from 2) carries block byte k-2, top byte first
   wire [4:0] bsel = (tx_cnt == 5'h0) ? 5'h1 : tx_cnt;
   assign blk_byte = lk.block[frec_pkg::ENTRY_W + 7 - 8 * int'(bsel) -: 8];
   always_comb begin
      next_tx = frec_pkg::EMPTY_BYTE;
      if (ready && cmd == frec_pkg::CMD_EVENT_INDEX) begin
         next_tx = lk.readback;
      end else if (ready && cmd == frec_pkg::CMD_READ_EVENT) begin
         next_tx = (tx_cnt == 5'h0) ? frec_pkg::BLOCK_COUNT : blk_byte;
      end
   end
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         in_frame <= 1'b0;
         got_data <= 1'b0;
         cmd <= 8'h00;
         tx_cnt <= 5'h0;
         lk.wr_tgl <= 1'b0;
         lk.clr_tgl <= 1'b0;
         lk.index_byte <= 8'h00;
         link_tx_byte <= frec_pkg::EMPTY_BYTE;
      end else if (!link_frame) begin
         in_frame <= 1'b0;
         got_data <= 1'b0;
         tx_cnt <= 5'h0;
      end else begin
         if (first) begin
            in_frame <= 1'b1;
            cmd <= link_rx_byte;
            if (link_rx_byte == frec_pkg::CMD_CLEAR_FAULTS) begin
               lk.clr_tgl <= ~lk.clr_tgl;
            end
         end else if (link_rx_valid && !got_data && cmd == frec_pkg::CMD_EVENT_INDEX) begin
            got_data <= 1'b1;
            lk.index_byte <= link_rx_byte;
            lk.wr_tgl <= ~lk.wr_tgl;
         end
         if (link_tx_req) begin
            link_tx_byte <= next_tx;
            if (tx_cnt != 5'h17) begin
               tx_cnt <= tx_cnt + 5'h1;
            end
         end
      end
   end
endmodule

// ---- hdl/frec_core.sv ----
`timescale 1ns/1ps
// Functional notes
// - unmasked active condition drives alert low
// - alert holds until clear or re-enable
// - masked conditions never assert the alert
// - 48 slots, 24 for faults
// - mask selects which conditions log faults
// - each section first-in first-out
// - full section drops its four oldest
// - event holds 16-bit id and 32-bit timestamp
// - live status word and bytes captured
// - telemetry stored at documented resolutions
// - unit on/off code with source
// - power good code one or zero
// - system event vendor codes
// - only some system events in fault section
// - 2.1 years idle logs cancel event
// - erase and clear log life events
// - index write reads back per code
// - 0xAA wipes fault section, resets ids
// - 0-23 fault, 24-47 life, oldest first
// - index write prepares block, empty is 0xFF
// - wipe takes 121 ms, faults suspended
// - read block 0xD7, 23 bytes, high first
module frec_core #(
   parameter int TICK_CYCLES = frec_pkg::TICK_CYCLES,
   parameter int WIPE_CYCLES = frec_pkg::WIPE_CYCLES,
   parameter int CANCEL_TICKS = frec_pkg::CANCEL_TICKS,
   parameter int COND_W = 8
) (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // link
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic link_frame,
   input wire logic link_rx_valid,
   input wire logic [7:0] link_rx_byte,
   input wire logic link_tx_req,
   output logic [7:0] link_tx_byte,
   // fault conditions
   input wire logic [COND_W-1:0] cond_live,
   input wire logic [COND_W-1:0] alert_mask,
   input wire logic vout_reenable,
   // live status
   input wire logic [15:0] status_word,
   input wire logic [7:0] status_vout,
   input wire logic [7:0] status_iout,
   input wire logic [7:0] status_input,
   input wire logic [7:0] status_temp,
   input wire logic [7:0] status_cml,
   input wire logic [7:0] status_other,
   input wire logic [7:0] vendor_status_byte,
   // telemetry
   input wire logic [15:0] tele_vin,
   input wire logic [15:0] tele_vout,
   input wire logic [15:0] tele_iout,
   input wire logic [15:0] tele_temp,
   // life-cycle events
   input wire logic input_low_evt,
   input wire logic unit_evt,
   input wire logic unit_on,
   input wire logic [1:0] unit_src,
   input wire logic power_good_evt,
   input wire logic power_good,
   // status out
   output logic fault_alert_n,
   output logic wipe_busy
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int WW = $clog2(WIPE_CYCLES + 1);
   localparam int CW = $clog2(CANCEL_TICKS + 1);
   localparam int NSRC = 9;
   // source bits: 0 fault, 1 overload, 2 cancel, 3 input low, 4 boot, 5 clear, 6 erase, 7 unit, 8 power good

   function automatic logic [4:0] wrap(input logic [5:0] a);
      wrap = (a >= 6'd24) ? 5'(a - 6'd24) : a[4:0];
   endfunction

   frec_link_if lk ();
   frec_link u_link (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .link_frame(link_frame),
      .link_rx_valid(link_rx_valid),
      .link_rx_byte(link_rx_byte),
      .link_tx_req(link_tx_req),
      .link_tx_byte(link_tx_byte),
      .lk(lk)
   );

   logic [1:0] tgl_s;
   logic [1:0] tgl_d;
   frec_sync #(.W(2)) u_sync (.clk(sys_clk), .rst_n(rst_n), .d({lk.wr_tgl, lk.clr_tgl}), .q(tgl_s));
   wire idx_pulse = tgl_s[1] ^ tgl_d[1];
   wire clr_pulse = tgl_s[0] ^ tgl_d[0];

   frec_pkg::frec_state_e state;
   logic [TW-1:0] tick_cnt;
   logic [31:0] stamp;
   logic [CW-1:0] idle_ticks;
   logic [WW-1:0] wipe_cnt;
   logic [15:0] event_id;
   logic [COND_W-1:0] active_d;
   logic [NSRC-1:0] pend;
   logic unit_on_h;
   logic [1:0] unit_src_h;
   logic pg_h;
   logic [4:0] head [2];
   logic [4:0] cnt [2];
   logic [frec_pkg::ENTRY_W-1:0] mem [frec_pkg::SLOTS];

   // alert and fault detection
   wire run = (state == frec_pkg::ST_RUN);
   wire [COND_W-1:0] active = cond_live & ~alert_mask;
   wire new_fault = run && |(active & ~active_d);
   wire next_alert = (run && |active) || (!fault_alert_n && !clr_pulse && !vout_reenable);

   // time base
   wire tick = (tick_cnt == TW'(TICK_CYCLES - 1));
   wire cancel_due = tick && (idle_ticks == CW'(CANCEL_TICKS - 1));
   wire wipe_done = (state == frec_pkg::ST_WIPE) && (wipe_cnt == WW'(WIPE_CYCLES - 1));
   wire wipe_start = idx_pulse && run && (lk.index_byte == frec_pkg::IDX_WIPE);

   // event sources, a new request wins over the grant that clears it
   logic [NSRC-1:0] set_src;
   logic [NSRC-1:0] elig;
   logic [NSRC-1:0] grant;
   logic [NSRC-1:0] next_pend;
   assign set_src[0] = new_fault;
   assign set_src[2] = cancel_due;
   assign set_src[3] = input_low_evt;
   assign set_src[4] = 1'b0;
   assign set_src[5] = clr_pulse;
   assign set_src[6] = wipe_done;
   assign set_src[7] = unit_evt;
   assign set_src[8] = power_good_evt;
   assign set_src[1] = |({set_src[8:2], 1'b0, set_src[0]} & pend & ~grant);
   assign elig = run ? pend : (pend & ~9'h003);
   assign grant = elig & (~elig + 9'h001);
   assign next_pend = set_src | (pend & ~grant);

   // entry contents for the granted source
   wire fsec = |grant[1:0];
   logic [15:0] ev_sw;
   logic [7:0] ev_vendor;
   always_comb begin
      ev_sw = frec_pkg::SW_SYSTEM;
      ev_vendor = frec_pkg::SYS_BOOT;
      if (grant[0]) begin
         ev_sw = status_word;
         ev_vendor = vendor_status_byte;
      end else if (grant[1]) begin
         ev_vendor = frec_pkg::SYS_WIPE_OVERLOAD;
      end else if (grant[2]) begin
         ev_vendor = frec_pkg::SYS_CANCEL;
      end else if (grant[3]) begin
         ev_vendor = frec_pkg::SYS_INPUT_LOW;
      end else if (grant[5]) begin
         ev_vendor = frec_pkg::SYS_FAULT_CLEAR;
      end else if (grant[6]) begin
         ev_vendor = frec_pkg::SYS_ERASE;
      end else if (grant[7]) begin
         ev_sw = frec_pkg::SW_UNIT;
         ev_vendor = (unit_on_h ? frec_pkg::UNIT_ENABLED_CODE : frec_pkg::UNIT_DISABLED_CODE)
            | {6'h00, unit_src_h};
      end else if (grant[8]) begin
         ev_sw = frec_pkg::SW_POWER_GOOD;
         ev_vendor = {7'h00, pg_h};
      end
   end
   wire [frec_pkg::ENTRY_W-1:0] entry = {event_id, stamp, ev_sw,
      status_vout, status_iout, status_input, status_temp, status_cml, status_other, ev_vendor,
      tele_vin, tele_vout, tele_iout, tele_temp};

   // write position, a full section first drops its oldest four
   wire [4:0] w_head = head[fsec ? 0 : 1];
   wire [4:0] w_cnt = cnt[fsec ? 0 : 1];
   wire w_full = (w_cnt == 5'(frec_pkg::SECT_SLOTS));
   wire [4:0] next_head = w_full ? wrap({1'b0, w_head} + 6'(frec_pkg::ERASE_BATCH)) : w_head;
   wire [4:0] fill = w_full ? 5'(frec_pkg::SECT_SLOTS - frec_pkg::ERASE_BATCH) : w_cnt;
   wire [5:0] w_slot = (fsec ? 6'd0 : 6'(frec_pkg::SECT_SLOTS)) + {1'b0, wrap({1'b0, next_head} + {1'b0, fill})};

   // index decode for readback and block selection
   wire [7:0] ix = lk.index_byte;
   wire [7:0] newest_life = (cnt[1] == 5'h0) ? frec_pkg::EMPTY_BYTE : 8'(frec_pkg::SECT_SLOTS) + {3'h0, cnt[1]} - 8'h01;
   wire [7:0] newest_fault = (cnt[0] == 5'h0) ? frec_pkg::EMPTY_BYTE : {3'h0, cnt[0]} - 8'h01;
   wire [7:0] rb = (ix == frec_pkg::IDX_NEWEST_LIFE) ? newest_life :
                   (ix == frec_pkg::IDX_NEWEST_FAULT) ? newest_fault : ix;
   wire in_range = rb < 8'(frec_pkg::SLOTS);
   wire r_life = rb >= 8'(frec_pkg::SECT_SLOTS);
   wire [4:0] r_off = r_life ? 5'(rb - 8'(frec_pkg::SECT_SLOTS)) : rb[4:0];
   wire r_valid = in_range && (r_off < cnt[r_life ? 1 : 0]);
   wire [5:0] r_slot = (r_life ? 6'(frec_pkg::SECT_SLOTS) : 6'd0) + {1'b0, wrap({1'b0, head[r_life ? 1 : 0]} + {1'b0, r_off})};
   wire [frec_pkg::ENTRY_W-1:0] r_entry = r_valid ? mem[r_slot] : {frec_pkg::ENTRY_W{1'b1}};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tgl_d <= 2'b00;
         active_d <= '0;
         fault_alert_n <= 1'b1;
      end else begin
         tgl_d <= tgl_s;
         active_d <= run ? active : '0;
         fault_alert_n <= ~next_alert;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         stamp <= 32'h0000_0000;
         idle_ticks <= '0;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
         stamp <= stamp + {31'h0000_0000, tick};
         if (|grant) begin
            idle_ticks <= '0;
         end else if (tick) begin
            idle_ticks <= cancel_due ? '0 : idle_ticks + CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend <= 9'h010;
         unit_on_h <= 1'b0;
         unit_src_h <= frec_pkg::SRC_CFG;
         pg_h <= 1'b0;
      end else begin
         pend <= next_pend;
         if (unit_evt) begin
            unit_on_h <= unit_on;
            unit_src_h <= unit_src;
         end
         if (power_good_evt) begin
            pg_h <= power_good;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= frec_pkg::ST_RUN;
         wipe_cnt <= '0;
         wipe_busy <= 1'b0;
         event_id <= 16'h0000;
         head[0] <= 5'h0;
         head[1] <= 5'h0;
         cnt[0] <= 5'h0;
         cnt[1] <= 5'h0;
      end else begin
         if (|grant) begin
            mem[w_slot] <= entry;
            head[fsec ? 0 : 1] <= next_head;
            cnt[fsec ? 0 : 1] <= fill + 5'h1;
            event_id <= event_id + 16'h0001;
         end
         case (state)
            frec_pkg::ST_RUN: begin
               if (wipe_start) begin
                  state <= frec_pkg::ST_WIPE;
                  wipe_cnt <= '0;
                  wipe_busy <= 1'b1;
                  event_id <= 16'h0000;
                  head[0] <= 5'h0;
                  cnt[0] <= 5'h0;
               end
            end
            frec_pkg::ST_WIPE: begin
               wipe_cnt <= wipe_cnt + WW'(1);
               if (wipe_done) begin
                  state <= frec_pkg::ST_RUN;
                  wipe_busy <= 1'b0;
               end
            end
            default: begin
               state <= frec_pkg::ST_RUN;
            end
         endcase
      end
   end

   // block snapshot held stable for the link, then handed over
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lk.prep_tgl <= 1'b0;
         lk.readback <= frec_pkg::EMPTY_BYTE;
         lk.block <= {frec_pkg::ENTRY_W{1'b1}};
      end else if (idx_pulse) begin
         lk.readback <= rb;
         lk.block <= (ix == frec_pkg::IDX_WIPE) ? {frec_pkg::ENTRY_W{1'b1}} : r_entry;
         lk.prep_tgl <= tgl_s[1];
      end
   end
endmodule

// ---- verif/frec_monitor.sv ----
`timescale 1ns/1ps
module frec_monitor #(
   parameter int COND_W = 8,
   parameter int WIPE_CYCLES = 50
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // watched ports
   input wire logic [COND_W-1:0] cond_live,
   input wire logic [COND_W-1:0] alert_mask,
   input wire logic vout_reenable,
   input wire logic fault_alert_n,
   input wire logic wipe_busy
);
   logic act;
   int wcnt;
   assign act = |(cond_live & ~alert_mask);
   // cycles spent with the wipe flag up
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !wipe_busy) begin
         wcnt <= 0;
      end else begin
         wcnt <= wcnt + 1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_ALERT_SET: assert property (act && !wipe_busy |=> !fault_alert_n)
      else $error("alert not raised");
   AST_RISE_CAUSE: assert property ($rose(fault_alert_n) |-> !$past(act) || $past(wipe_busy))
      else $error("alert released while active");
   AST_SET_WINS: assert property (!fault_alert_n && act && !wipe_busy |=> !fault_alert_n)
      else $error("alert dropped under condition");
   AST_REEN_CLEAR: assert property (vout_reenable && !act |=> fault_alert_n)
      else $error("re-enable did not release alert");
   AST_MASKED: assert property (fault_alert_n && !act |=> fault_alert_n)
      else $error("alert without unmasked condition");
   AST_WIPE_QUIET: assert property (wipe_busy && fault_alert_n |=> fault_alert_n)
      else $error("alert raised during wipe");
   AST_WIPE_LEN: assert property ($fell(wipe_busy) |-> wcnt == WIPE_CYCLES)
      else $error("wipe length wrong");
   AST_WIPE_SPAN: assert property ($rose(wipe_busy) |=> wipe_busy [*8])
      else $error("wipe ended early");
endmodule

// ---- verif/frec_host.sv ----
`timescale 1ns/1ps
module frec_host (
   // link clock
   input wire logic link_clk,
   // link pins
   output logic link_frame,
   output logic link_rx_valid,
   output logic [7:0] link_rx_byte,
   output logic link_tx_req,
   input wire logic [7:0] link_tx_byte
);
   logic [7:0] rdbuf [0:23];
   initial begin
      link_frame = 1'b0;
      link_rx_valid = 1'b0;
      link_rx_byte = 8'h00;
      link_tx_req = 1'b0;
   end
   // one byte inside an open frame, data line scrambled afterwards
   task automatic put(input logic [7:0] b);
      @(negedge link_clk) link_frame = 1'b1;
      link_rx_valid = 1'b1;
      link_rx_byte = b;
      @(negedge link_clk) link_rx_valid = 1'b0;
      link_rx_byte = ~b;
   endtask
   task automatic close();
      @(negedge link_clk) link_frame = 1'b0;
      @(negedge link_clk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      put(c);
      put(d);
      close();
      #30_000;
   endtask
   task automatic clr();
      put(8'h03);
      close();
   endtask
   // byte k is taken after the k-th request edge
   task automatic rd(input logic [7:0] c, input int n);
      put(c);
      for (int i = 0; i <= n; i++) begin
         @(negedge link_clk) link_tx_req = i < n;
         if (i > 0) rdbuf[i - 1] = link_tx_byte;
      end
      close();
   endtask
endmodule

// ---- verif/frec_core_test.sv ----
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin n_fail++; $display("[ERR] %0t %h %h",$time,a,b); end end
module frec_core_test;
   logic sys_clk, rst_n, link_clk, link_frame, link_rx_valid, link_tx_req, seen;
   logic vout_reenable, input_low_evt, unit_evt, unit_on, power_good_evt, power_good, fault_alert_n, wipe_busy;
   logic [1:0] unit_src;
   logic [7:0] link_rx_byte, link_tx_byte, cond_live, alert_mask;
   logic [135:0] ev;
   int n_fail = 0, checked = 0, nlife = 0;
   frec_core #(.TICK_CYCLES(20), .WIPE_CYCLES(50), .CANCEL_TICKS(400)) frec_core_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(rst_n), .link_frame(link_frame),
      .link_rx_valid(link_rx_valid), .link_rx_byte(link_rx_byte), .link_tx_req(link_tx_req),
      .link_tx_byte(link_tx_byte), .cond_live(cond_live), .alert_mask(alert_mask), .vout_reenable(vout_reenable),
      .status_word(ev[135:120]), .status_vout(ev[119:112]), .status_iout(ev[111:104]), .status_input(ev[103:96]),
      .status_temp(ev[95:88]), .status_cml(ev[87:80]), .status_other(ev[79:72]), .vendor_status_byte(ev[71:64]),
      .tele_vin(ev[63:48]), .tele_vout(ev[47:32]), .tele_iout(ev[31:16]), .tele_temp(ev[15:0]),
      .input_low_evt(input_low_evt), .unit_evt(unit_evt), .unit_on(unit_on), .unit_src(unit_src),
      .power_good_evt(power_good_evt), .power_good(power_good), .fault_alert_n(fault_alert_n), .wipe_busy(wipe_busy)
   );
   frec_host frec_host_inst (
      .link_clk(link_clk), .link_frame(link_frame), .link_rx_valid(link_rx_valid), .link_rx_byte(link_rx_byte),
      .link_tx_req(link_tx_req), .link_tx_byte(link_tx_byte)
   );
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   always @(posedge sys_clk) if (wipe_busy) seen <= 1'b1;
   task automatic test_done();
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic sel(input logic [7:0] i);
      frec_host_inst.wr(8'hDB, i);
   endtask
   task automatic rb(input logic [7:0] i, input logic [7:0] e);
      sel(i);
      frec_host_inst.rd(8'hDB, 1);
      `CHK(frec_host_inst.rdbuf[0], e)
   endtask
   task automatic blk(input logic [7:0] i);
      sel(i);
      frec_host_inst.rd(8'hD7, 24);
      `CHK(frec_host_inst.rdbuf[0], 8'h17)
   endtask
   // newest life entry: status word and vendor byte
   task automatic life(input logic [15:0] sw, input logic [7:0] vend);
      nlife++;
      blk(8'(23 + nlife));
      `CHK({frec_host_inst.rdbuf[7], frec_host_inst.rdbuf[8]}, sw)
      `CHK(frec_host_inst.rdbuf[15], vend)
   endtask
   task automatic fault(input int b);
      @(negedge sys_clk) cond_live[b] = 1'b1;
      repeat (2) @(negedge sys_clk);
      cond_live[b] = 1'b0;
      @(negedge sys_clk);
   endtask
   initial begin
      {rst_n, cond_live, vout_reenable, input_low_evt, unit_evt, unit_on, unit_src} = '0;
      {power_good, power_good_evt, seen} = '0;
      alert_mask = 8'h02;
      ev = 136'h00_8011_2233_4455_6677_0123_4567_89AB_CDEF;
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      life(16'h0001, 8'h01);
      `CHK({frec_host_inst.rdbuf[1], frec_host_inst.rdbuf[2]}, 16'h0000)
      `CHK(frec_host_inst.rdbuf[6], 8'h00)
      rb(8'hFE, 8'd24);
      rb(8'hFF, 8'hFF);
      rb(8'd47, 8'd47);
      blk(8'd0);
      for (int i = 1; i < 24; i++) `CHK(frec_host_inst.rdbuf[i], 8'hFF)
      $display("index test done");
      fault(0);
      `CHK(fault_alert_n, 1'b0)
      blk(8'd0);
      for (int i = 0; i < 17; i++) `CHK(frec_host_inst.rdbuf[7 + i], ev[135 - 8 * i -: 8])
      frec_host_inst.clr();
      repeat (20) @(negedge sys_clk);
      `CHK(fault_alert_n, 1'b1)
      life(16'h0001, 8'h10);
      fault(1);
      `CHK(fault_alert_n, 1'b1)
      rb(8'hFF, 8'd0);
      fault(2);
      `CHK(fault_alert_n, 1'b0)
      @(negedge sys_clk) vout_reenable = 1'b1;
      @(negedge sys_clk) vout_reenable = 1'b0;
      `CHK(fault_alert_n, 1'b1)
      $display("alert test done");
      for (int k = 0; k < 8; k++) begin
         @(negedge sys_clk) unit_evt = 1'b1;
         {unit_on, unit_src} = 3'(k);
         @(negedge sys_clk) unit_evt = 1'b0;
         life(16'h0040, 8'(k));
      end
      for (int k = 0; k < 3; k++) begin
         @(negedge sys_clk) power_good = k[0];
         power_good_evt = k < 2;
         input_low_evt = k == 2;
         @(negedge sys_clk) power_good_evt = 1'b0;
         input_low_evt = 1'b0;
         life(k < 2 ? 16'h0800 : 16'h0001, k < 2 ? 8'(k) : 8'h02);
      end
      $display("life test done");
      for (int k = 0; k < 23; k++) begin
         ev[119:112] = 8'h10 + 8'(k);
         fault(0);
      end
      rb(8'hFF, 8'd20);
      blk(8'd0);
      `CHK(frec_host_inst.rdbuf[9], 8'h12)
      $display("fill test done");
      sel(8'hAA);
      `CHK(seen, 1'b1)
      `CHK(wipe_busy, 1'b0)
      frec_host_inst.rd(8'hDB, 1);
      `CHK(frec_host_inst.rdbuf[0], 8'hAA)
      rb(8'hFF, 8'hFF);
      life(16'h0001, 8'h08);
      $display("wipe test done");
      repeat (8200) @(negedge sys_clk);
      life(16'h0001, 8'h04);
      $display("idle test done");
      test_done();
   end
   initial begin
      #4_500_000;
      n_fail++;
      test_done();
   end
endmodule
bind frec_core frec_monitor #(.COND_W(COND_W), .WIPE_CYCLES(WIPE_CYCLES)) frec_monitor_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .cond_live(cond_live), .alert_mask(alert_mask),
   .vout_reenable(vout_reenable), .fault_alert_n(fault_alert_n), .wipe_busy(wipe_busy)
);
